// ===== design/scratch_ctl_pkg.sv
package scratch_ctl_pkg;
    // apb register map
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] CTRL_OFF = 8'h04;
    localparam logic [7:0] JAM_OFF = 8'h08;
    // status register fields
    localparam int STATUS_SW_LSB = 0;
    localparam int STATUS_HIST_LSB = 16;
    // control register fields
    localparam int CTRL_INIT_BIT = 0;
    localparam int CTRL_GATE_BIT = 1;
    localparam logic CTRL_GATE_RST = 1'b1;
    // jam register fields
    localparam int JAM_PEND_LSB = 0;
    localparam int JAM_STATE_LSB = 8;
    // reset values
    localparam logic [7:0] SW_RST = 8'h00;
    localparam logic [8:0] HIST_RST = 9'h000;
    // forced entry addresses, plain defaults
    localparam logic [8:0] JAM_VEC_PWRUP = 9'h001;
    localparam logic [8:0] JAM_VEC_BUSERR = 9'h002;
    localparam logic [8:0] JAM_VEC_STACK = 9'h003;
    localparam logic [8:0] JAM_VEC_INIT = 9'h004;
    // pending bit order, highest priority first
    localparam int PEND_PWRUP = 0;
    localparam int PEND_BUSERR = 1;
    localparam int PEND_STACK = 2;
    localparam int PEND_INIT = 3;
    // scratch file read/write control codes
    localparam logic [1:0] RW_READ = 2'h0;
    localparam logic [1:0] RW_LOW = 2'h1;
    localparam logic [1:0] RW_HIGH = 2'h2;
    localparam logic [1:0] RW_WORD = 2'h3;
    // forced address sequencer
    typedef enum logic [2:0] {
        JAM_IDLE = 3'b001,
        JAM_FORCE = 3'b010,
        JAM_LOAD = 3'b100
    } jam_state_t;
endpackage : scratch_ctl_pkg

// ===== design/scratch_if.sv
`timescale 1ns/1ns
interface scratch_if;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [1:0] rw_ctrl;
    logic [15:0] rdata;
    modport ctrl (output addr, output wdata, output rw_ctrl,
        input rdata);
    modport mem (input addr, input wdata, input rw_ctrl,
        output rdata);
endinterface : scratch_if

// ===== design/scratch_file.sv
`timescale 1ns/1ns
module scratch_file
    import scratch_ctl_pkg::*;
(
    // clock
    input wire logic pclk,
    // control side
    scratch_if.mem port
);
    logic [15:0] words [16];

    // byte lane writes under the two-bit control
    always_ff @(posedge pclk) begin
        if (port.rw_ctrl[0]) begin
            words[port.addr][7:0] <= port.wdata[7:0];
        end
        if (port.rw_ctrl[1]) begin
            words[port.addr][15:8] <= port.wdata[15:8];
        end
    end

    // selected word read straight out
    assign port.rdata = words[port.addr];
endmodule : scratch_file

// ===== design/scratchpad_status_micro_jam_control.sv
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - sixteen by sixteen scratch file, read and write
// - data mux in, four-bit address, two-bit control
// - read word drives the register read bus
// - one of four address sources per microword
// - destination select uses instruction bits 2:0
// - source select uses instruction bits 8:6
// - immediate select uses microword register field
// - bus-address select uses bus address bits 3:0
// - status word loads from mux or conditions
// - status gates onto system or read bus
// - status bits feed branch decode and microbranch
// - history register captures pointer every clock with ce high
// - history register shown on display output
// - four exceptional conditions force a microaddress
// - forcing drives set and clear pointer bits
// - forcing ends with a buffer load strobe
// - instruction decoded into alu and branch controls
// - microbranch data modifies base address by test
// - pointer picks one of 512 control words
module scratchpad_status_micro_jam_control
    import scratch_ctl_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // scratch file controls from the microword
    input wire logic [15:0] d_data_mux,
    input wire logic [1:0] reg_rw_ctrl,
    input wire logic sel_dest_field,
    input wire logic sel_src_field,
    input wire logic sel_immediate_field,
    input wire logic sel_bus_addr_field,
    input wire logic [3:0] microword_reg_field,
    input wire logic [3:0] bus_addr_low,
    // status word controls
    input wire logic sw_load_dmux,
    input wire logic sw_load_cc,
    input wire logic [7:0] cc_in,
    input wire logic sw_to_sysbus,
    input wire logic sw_to_readbus,
    // instruction and microbranch
    input wire logic [15:0] instr_reg,
    input wire logic [1:0] branch_test_sel,
    input wire logic [3:0] machine_status,
    input wire logic [8:0] micro_pointer,
    // forcing conditions
    input wire logic bus_error,
    input wire logic stack_red_zone,
    input wire logic power_up_restart,
    input wire logic console_init,
    // read bus and status outputs
    output logic [15:0] reg_read_bus,
    output logic [7:0] sys_bus_data,
    output logic sys_bus_data_oe,
    output logic [7:0] processor_status_word,
    output logic [8:0] previous_micro_pointer,
    // decode and microbranch outputs
    output logic [3:0] alu_ctrl,
    output logic fmt_double,
    output logic fmt_single,
    output logic fmt_branch,
    output logic branch_true,
    output logic [3:0] branch_test_mux,
    // forced address outputs
    output logic [8:0] jam_set,
    output logic [8:0] jam_clr,
    output logic jam_load,
    output logic jam_busy
);
    scratch_if scr ();
    logic ctrl_gate;
    logic init_req;
    logic [3:0] pend;
    jam_state_t jam_state;
    logic [1:0] jam_pick;
    logic [1:0] jam_served;
    logic next_double;
    logic next_single;
    logic next_branch;
    logic next_taken;
    logic apb_go;
    logic apb_done;

    // one-hot source select, destination wins a clash
    function automatic logic [3:0] pick_addr(
        input logic sd, input logic ss, input logic si,
        input logic [15:0] iw, input logic [3:0] mrf,
        input logic [3:0] ba);
        if (sd) begin
            return {1'b0, iw[2:0]};
        end else if (ss) begin
            return {1'b0, iw[8:6]};
        end else if (si) begin
            return mrf;
        end
        return ba;
    endfunction : pick_addr

    // branch condition from status bits n z v c
    function automatic logic cond_true(
        input logic [15:0] iw, input logic [3:0] c);
        logic r;
        r = 1'b0;
        unique case (iw[10:8])
            3'h0: r = 1'b1;
            3'h1: r = c[2];
            3'h2: r = c[3] ^ c[1];
            3'h3: r = (c[3] ^ c[1]) | c[2];
            3'h4: r = c[3];
            3'h5: r = c[0] | c[2];
            3'h6: r = c[1];
            3'h7: r = c[0];
        endcase
        return r ^ iw[15];
    endfunction : cond_true

    // forced entry address by pending index
    function automatic logic [8:0] jam_vec(input logic [1:0] i);
        logic [8:0] v;
        v = JAM_VEC_INIT;
        unique case (i)
            2'd0: v = JAM_VEC_PWRUP;
            2'd1: v = JAM_VEC_BUSERR;
            2'd2: v = JAM_VEC_STACK;
            2'd3: v = JAM_VEC_INIT;
        endcase
        return v;
    endfunction : jam_vec

    // scratch file address and write control
    always_comb begin
        scr.addr = pick_addr(sel_dest_field, sel_src_field,
            sel_immediate_field, instr_reg, microword_reg_field,
            bus_addr_low);
        scr.wdata = d_data_mux;
        scr.rw_ctrl = ce ? reg_rw_ctrl : RW_READ;
    end

    scratch_file u_file (
        .pclk(pclk),
        .port(scr)
    );

    // read bus: scratch word or status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_read_bus <= 16'h0000;
        end else if (ce) begin
            if (sw_to_readbus) begin
                reg_read_bus <= {8'h00, processor_status_word};
            end else begin
                reg_read_bus <= scr.rdata;
            end
        end
    end

    // status word load, data mux before condition logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            processor_status_word <= SW_RST;
        end else if (ce) begin
            if (sw_load_dmux) begin
                processor_status_word <= d_data_mux[7:0];
            end else if (sw_load_cc) begin
                processor_status_word <= cc_in;
            end
        end
    end

    // status onto system bus lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_bus_data <= 8'h00;
            sys_bus_data_oe <= 1'b0;
        end else if (ce) begin
            sys_bus_data_oe <= sw_to_sysbus & ctrl_gate;
            sys_bus_data <= (sw_to_sysbus & ctrl_gate) ?
                processor_status_word : 8'h00;
        end
    end

    // history of the executing microword address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            previous_micro_pointer <= HIST_RST;
        end else if (ce) begin
            previous_micro_pointer <= micro_pointer;
        end
    end

    // instruction format decode
    always_comb begin
        next_double = instr_reg[14:12] != 3'h0
            && instr_reg[14:12] != 3'h7;
        next_branch = instr_reg[14:12] == 3'h0
            && instr_reg[11] == 1'b0 && instr_reg[10:8] != 3'h0;
        next_single = instr_reg[14:12] == 3'h0
            && instr_reg[11] == 1'b1;
        next_taken = next_branch
            && cond_true(instr_reg, processor_status_word[3:0]);
    end

    // registered decode controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu_ctrl <= 4'h0;
            fmt_double <= 1'b0;
            fmt_single <= 1'b0;
            fmt_branch <= 1'b0;
            branch_true <= 1'b0;
        end else if (ce) begin
            alu_ctrl <= next_double ? instr_reg[15:12]
                : instr_reg[9:6];
            fmt_double <= next_double;
            fmt_single <= next_single;
            fmt_branch <= next_branch;
            branch_true <= next_taken;
        end
    end

    // microbranch data chosen by the test selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch_test_mux <= 4'h0;
        end else if (ce) begin
            unique case (branch_test_sel)
                2'h0: branch_test_mux <= 4'h0;
                2'h1: branch_test_mux <= {1'b0, instr_reg[5:3]};
                2'h2: branch_test_mux <= {next_double, next_single,
                    next_branch, next_taken};
                2'h3: branch_test_mux <= machine_status ^
                    {processor_status_word[3:0]};
            endcase
        end
    end

    // highest priority pending condition
    always_comb begin
        if (pend[PEND_PWRUP]) begin
            jam_pick = 2'd0;
        end else if (pend[PEND_BUSERR]) begin
            jam_pick = 2'd1;
        end else if (pend[PEND_STACK]) begin
            jam_pick = 2'd2;
        end else begin
            jam_pick = 2'd3;
        end
    end

    // sticky pending flags, a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                if (jam_state == JAM_LOAD && jam_served == 2'(i)) begin
                    pend[i] <= 1'b0;
                end
            end
            if (power_up_restart) pend[PEND_PWRUP] <= 1'b1;
            if (bus_error) pend[PEND_BUSERR] <= 1'b1;
            if (stack_red_zone) pend[PEND_STACK] <= 1'b1;
            if (console_init | init_req) pend[PEND_INIT] <= 1'b1;
        end
    end

    // force set and clear, then strobe the buffer load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jam_state <= JAM_IDLE;
            jam_set <= 9'h000;
            jam_clr <= 9'h000;
            jam_load <= 1'b0;
            jam_busy <= 1'b0;
            jam_served <= 2'd0;
        end else if (ce) begin
            unique case (jam_state)
                JAM_IDLE: if (pend != 4'h0) begin
                    jam_state <= JAM_FORCE;
                    jam_set <= jam_vec(jam_pick);
                    jam_clr <= ~jam_vec(jam_pick);
                    jam_busy <= 1'b1;
                    // keep the served source, a later event may outrank it
                    jam_served <= jam_pick;
                end
                JAM_FORCE: begin
                    jam_state <= JAM_LOAD;
                    jam_load <= 1'b1;
                end
                JAM_LOAD: begin
                    jam_state <= JAM_IDLE;
                    jam_load <= 1'b0;
                    jam_set <= 9'h000;
                    jam_clr <= 9'h000;
                    jam_busy <= 1'b0;
                end
                default: jam_state <= JAM_IDLE;
            endcase
        end
    end

    // apb: answer one cycle into the access phase
    assign apb_go = psel & penable & ~pready;
    assign apb_done = psel & penable & pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= apb_go;
            pslverr <= apb_go && paddr != STATUS_OFF
                && paddr != CTRL_OFF && paddr != JAM_OFF;
            prdata <= 32'h0000_0000;
            if (apb_go && !pwrite) begin
                unique case (paddr)
                    STATUS_OFF: begin
                        prdata[STATUS_SW_LSB +: 8] <=
                            processor_status_word;
                        prdata[STATUS_HIST_LSB +: 9] <=
                            previous_micro_pointer;
                    end
                    CTRL_OFF: prdata[CTRL_GATE_BIT] <= ctrl_gate;
                    JAM_OFF: begin
                        prdata[JAM_PEND_LSB +: 4] <= pend;
                        prdata[JAM_STATE_LSB +: 3] <= jam_state;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register write, init request is a pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_gate <= CTRL_GATE_RST;
            init_req <= 1'b0;
        end else if (ce) begin
            init_req <= 1'b0;
            if (apb_done && pwrite && paddr == CTRL_OFF) begin
                ctrl_gate <= pwdata[CTRL_GATE_BIT];
                init_req <= pwdata[CTRL_INIT_BIT];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hist_capture: assert property (ce |=>
        previous_micro_pointer == $past(micro_pointer))
        else $error("history missed the pointer");
    a_addr_dest: assert property (sel_dest_field |->
        scr.addr == {1'b0, instr_reg[2:0]})
        else $error("destination address wrong");
    a_addr_src: assert property (
        !sel_dest_field && sel_src_field |->
        scr.addr == {1'b0, instr_reg[8:6]})
        else $error("source address wrong");
    a_addr_busaddr: assert property (
        !(sel_dest_field | sel_src_field | sel_immediate_field)
        |-> scr.addr == bus_addr_low)
        else $error("bus address select wrong");
    a_sw_load: assert property (ce && sw_load_dmux |=>
        processor_status_word == $past(d_data_mux[7:0]))
        else $error("status word not loaded");
    a_sw_sysbus: assert property (
        ce && sw_to_sysbus && ctrl_gate |=> sys_bus_data_oe
        && sys_bus_data == $past(processor_status_word))
        else $error("status not on system bus");
    a_jam_start: assert property (
        ce && jam_state == JAM_IDLE && pend != 4'h0
        |=> jam_state == JAM_FORCE && jam_busy)
        else $error("forcing did not start");
    a_jam_setclr: assert property ($rose(jam_busy) |->
        (jam_set ^ jam_clr) == 9'h1ff ##1 !ce || jam_load)
        else $error("set and clear not complementary");
    a_jam_load: assert property (
        ce && jam_state == JAM_FORCE |=> jam_load [*1] ##1 !ce
        || !jam_load)
        else $error("load strobe not one cycle");
    a_jam_prio: assert property (
        ce && jam_state == JAM_IDLE && pend[PEND_PWRUP]
        |=> jam_set == JAM_VEC_PWRUP)
        else $error("power-up not served first");
    a_apb_answer: assert property (apb_go && ce |=> pready)
        else $error("apb answer late");

    c_force_each: cover property (jam_load ##1 !jam_load);
    c_two_pend: cover property (jam_state == JAM_IDLE
        && pend[PEND_PWRUP] && pend[PEND_BUSERR]);
    c_apb_read: cover property (apb_done && !pwrite && !pslverr);
    c_branch: cover property (fmt_branch && branch_true);
    c_busaddr_read: cover property (sel_bus_addr_field
        && scr.addr == bus_addr_low);
endmodule : scratchpad_status_micro_jam_control

// ===== verif/micro_seq_model.sv
`timescale 1ns/1ns
module micro_seq_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // forced address from the block
    input wire logic [8:0] jam_set,
    input wire logic [8:0] jam_clr,
    input wire logic jam_load,
    // pointer to the block
    output logic [8:0] micro_pointer
);
    // walk the 256 words, take the forced word on the load strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            micro_pointer <= 9'h000;
        end else if (ce && jam_load) begin
            micro_pointer <= (micro_pointer | jam_set) & ~jam_clr;
        end else if (ce) begin
            micro_pointer <= {1'b0, micro_pointer[7:0] + 8'h01};
        end
    end
endmodule : micro_seq_model

// ===== verif/scratchpad_status_micro_jam_control_tb_top.sv
`timescale 1ns/1ns
module scratchpad_status_micro_jam_control_tb_top
    import scratch_ctl_pkg::*;
;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, cc_in, sys_bus_data, processor_status_word;
    logic [31:0] pwdata, prdata;
    logic [15:0] d_data_mux, instr_reg, reg_read_bus;
    logic [1:0] reg_rw_ctrl, branch_test_sel;
    logic sel_dest_field, sel_src_field, sel_immediate_field;
    logic sel_bus_addr_field, sys_bus_data_oe, jam_load, jam_busy;
    logic [3:0] microword_reg_field, bus_addr_low, machine_status;
    logic sw_load_dmux, sw_load_cc, sw_to_sysbus, sw_to_readbus;
    logic [8:0] micro_pointer, previous_micro_pointer, jam_set, jam_clr;
    logic bus_error, stack_red_zone, power_up_restart, console_init;
    logic [3:0] alu_ctrl, branch_test_mux;
    logic fmt_double, fmt_single, fmt_branch, branch_true;
    int bad_count = 0;
    int n_compared = 0;

    scratchpad_status_micro_jam_control scratchpad_status_micro_jam_control_i (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .d_data_mux, .reg_rw_ctrl,
        .sel_dest_field, .sel_src_field, .sel_immediate_field,
        .sel_bus_addr_field, .microword_reg_field, .bus_addr_low,
        .sw_load_dmux, .sw_load_cc, .cc_in, .sw_to_sysbus, .sw_to_readbus,
        .instr_reg, .branch_test_sel, .machine_status, .micro_pointer,
        .bus_error, .stack_red_zone, .power_up_restart, .console_init,
        .reg_read_bus, .sys_bus_data, .sys_bus_data_oe,
        .processor_status_word, .previous_micro_pointer, .alu_ctrl,
        .fmt_double, .fmt_single, .fmt_branch, .branch_true,
        .branch_test_mux, .jam_set, .jam_clr, .jam_load, .jam_busy);

    micro_seq_model micro_seq_model_i (.pclk, .presetn, .ce, .jam_set,
        .jam_clr, .jam_load, .micro_pointer);

    // free running clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // a wait that ran out
    task automatic give_up();
        bad_count++;
        end_of_test();
    endtask : give_up

    // value compare
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) give_up();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // select order: dest, src, immediate, bus address
    task automatic sc_write(input logic [3:0] a, input logic [15:0] d,
        input logic [1:0] rw);
        @(posedge pclk);
        {sel_dest_field, sel_src_field, sel_immediate_field,
            sel_bus_addr_field} <= 4'b0010;
        microword_reg_field <= a;
        d_data_mux <= d;
        reg_rw_ctrl <= rw;
        @(posedge pclk);
        reg_rw_ctrl <= RW_READ;
    endtask : sc_write

    // read through one address source and compare
    task automatic sc_check(input logic [3:0] s, input logic [15:0] e);
        @(posedge pclk);
        {sel_dest_field, sel_src_field, sel_immediate_field,
            sel_bus_addr_field} <= s;
        @(posedge pclk);
        #1 chk(reg_read_bus, e);
    endtask : sc_check

    // register reset values and an unmapped address
    task automatic t_apb();
        logic [31:0] rd;
        logic er;
        apb(1'b0, CTRL_OFF, 32'h0, rd, er);
        chk({er, rd}, {1'b0, 30'h0, CTRL_GATE_RST, 1'b0});
        apb(1'b0, STATUS_OFF, 32'h0, rd, er);
        chk({er, rd[7:0]}, {1'b0, SW_RST});
        apb(1'b0, 8'h0c, 32'h0, rd, er);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b0, JAM_OFF, 32'h0, rd, er);
        chk(rd[10:0], 11'h100);
    endtask : t_apb

    // scratch file through every address source and byte lane
    task automatic t_scratch();
        sc_write(4'hc, 16'h5a5a, RW_WORD);
        sc_write(4'h3, 16'habcd, RW_WORD);
        sc_write(4'h5, 16'h1234, RW_WORD);
        sc_check(4'b0010, 16'h1234);
        sc_check(4'b1000, 16'h1234);
        sc_check(4'b0100, 16'habcd);
        sc_check(4'b0001, 16'h5a5a);
        sc_write(4'h5, 16'hffee, RW_LOW);
        sc_check(4'b0010, 16'h12ee);
        sc_write(4'h5, 16'h77ff, RW_HIGH);
        sc_check(4'b0010, 16'h77ee);
        sc_write(4'h5, 16'h0000, RW_READ);
        sc_check(4'b0010, 16'h77ee);
    endtask : t_scratch

    // status loads, gating and clock enable
    task automatic t_status();
        logic [31:0] rd;
        logic er;
        @(posedge pclk);
        sw_load_dmux <= 1'b1;
        sw_load_cc <= 1'b1;
        d_data_mux <= 16'hffa5;
        cc_in <= 8'h3c;
        @(posedge pclk);
        sw_load_dmux <= 1'b0;
        #1 chk(processor_status_word, 8'ha5);
        @(posedge pclk);
        sw_load_cc <= 1'b0;
        sw_to_sysbus <= 1'b1;
        sw_to_readbus <= 1'b1;
        #1 chk(processor_status_word, 8'h3c);
        @(posedge pclk);
        #1 chk({sys_bus_data_oe, sys_bus_data}, 9'h13c);
        chk(reg_read_bus, 16'h003c);
        apb(1'b1, CTRL_OFF, 32'h0, rd, er);
        @(posedge pclk);
        #1 chk(sys_bus_data_oe, 1'b0);
        apb(1'b0, STATUS_OFF, 32'h0, rd, er);
        chk(rd[7:0], 8'h3c);
        apb(1'b1, CTRL_OFF, 32'h2, rd, er);
        sw_to_sysbus <= 1'b0;
        sw_to_readbus <= 1'b0;
        ce <= 1'b0;
        sw_load_dmux <= 1'b1;
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
        sw_load_dmux <= 1'b0;
        #1 chk(processor_status_word, 8'h3c);
    endtask : t_status

    // history follows the pointer one edge late
    task automatic t_history();
        logic [8:0] p;
        repeat (3) begin
            @(posedge pclk);
            #1 p = micro_pointer;
            @(posedge pclk);
            #1 chk(previous_micro_pointer, p);
        end
    endtask : t_history

    // format decode, branch condition and microbranch data, status 3c
    task automatic t_decode();
        @(posedge pclk);
        instr_reg <= 16'h0100;
        branch_test_sel <= 2'h2;
        @(posedge pclk);
        #1 chk({fmt_double, fmt_single, fmt_branch, branch_true,
            branch_test_mux}, 8'h33);
        @(posedge pclk);
        instr_reg <= 16'h8100;
        @(posedge pclk);
        #1 chk({fmt_double, fmt_single, fmt_branch, branch_true,
            branch_test_mux}, 8'h22);
        @(posedge pclk);
        instr_reg <= 16'h1000;
        branch_test_sel <= 2'h3;
        @(posedge pclk);
        #1 chk({alu_ctrl, fmt_double, fmt_single, fmt_branch, branch_true,
            branch_test_mux}, 12'h18a);
    endtask : t_decode

    // one forcing sequence with the expected vector
    task automatic serve(input logic [8:0] v);
        int k;
        for (k = 0; k < 12; k++) begin
            @(posedge pclk);
            #1;
            if (jam_busy === 1'b1) break;
        end
        if (k == 12) give_up();
        chk({jam_load, jam_set, jam_clr}, {1'b0, v, ~v});
        @(posedge pclk);
        #1 chk({jam_load, jam_set}, {1'b1, v});
        @(posedge pclk);
        #1 chk({jam_load, jam_busy, jam_set, micro_pointer},
            {2'b00, 9'h000, v});
    endtask : serve

    // all four causes at once, a lone bus error, then console init from software
    task automatic t_force();
        logic [31:0] rd;
        logic er;
        @(posedge pclk);
        {console_init, stack_red_zone, bus_error, power_up_restart} <= 4'hf;
        @(posedge pclk);
        {console_init, stack_red_zone, bus_error, power_up_restart} <= 4'h0;
        serve(JAM_VEC_PWRUP);
        serve(JAM_VEC_BUSERR);
        serve(JAM_VEC_STACK);
        serve(JAM_VEC_INIT);
        @(posedge pclk);
        bus_error <= 1'b1;
        @(posedge pclk);
        bus_error <= 1'b0;
        serve(JAM_VEC_BUSERR);
        apb(1'b1, CTRL_OFF, 32'h3, rd, er);
        serve(JAM_VEC_INIT);
    endtask : t_force

    // reset, then the scenarios in turn
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0;
        d_data_mux = 16'h0000;
        reg_rw_ctrl = RW_READ;
        {sel_dest_field, sel_src_field} = 2'b00;
        {sel_immediate_field, sel_bus_addr_field} = 2'b00;
        microword_reg_field = 4'h0;
        bus_addr_low = 4'hc;
        {sw_load_dmux, sw_load_cc, sw_to_sysbus, sw_to_readbus} = 4'h0;
        cc_in = 8'h00;
        instr_reg = 16'h00c5;
        branch_test_sel = 2'h1;
        machine_status = 4'h6;
        {console_init, stack_red_zone, bus_error, power_up_restart} = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_apb();
        t_scratch();
        t_status();
        t_history();
        t_decode();
        t_force();
        end_of_test();
    end
endmodule : scratchpad_status_micro_jam_control_tb_top
